// File: include/fcm_cfg.svh
// Constants of the flash command master
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH
`define FCM_CMD_UNLOCK1 8'haa
`define FCM_CMD_UNLOCK2 8'h55
`define FCM_CMD_AUTOSEL 8'h90
`define FCM_CMD_PROG 8'ha0
`define FCM_CMD_BYPASS 8'h20
`define FCM_CMD_ERASE_SETUP 8'h80
`define FCM_CMD_CHIP_ERASE 8'h10
`define FCM_CMD_RESET 8'hf0
`define FCM_CMD_BYP_EXIT 8'h00
`define FCM_UNLOCK_ADDR 20'h00000
`define FCM_AS_MANUF 20'h00000
`define FCM_AS_DEVICE 20'h00001
`define FCM_AS_PROT 20'h00002
`define FCM_SEC_LSB 16
`define FCM_REG_CTRL 4'h0
`define FCM_REG_ADDR 4'h1
`define FCM_REG_DATA 4'h2
`define FCM_REG_STAT 4'h3
`define FCM_REG_RDATA 4'h4
`define FCM_PULSE_NS 50
`define FCM_PULSE_CYC ((`FCM_PULSE_NS + 9) / 10)
`define FCM_GAP_NS 30
`define FCM_GAP_CYC ((`FCM_GAP_NS + 9) / 10)
`define FCM_RD_NS 120
`define FCM_RD_CYC ((`FCM_RD_NS + 9) / 10)
`endif

// File: include/fcm_pkg.sv
// Types of the flash command master
package fcm_pkg;
    typedef enum logic [3:0] {
        FCM_OP_RESET, FCM_OP_AUTOSEL, FCM_OP_PROGRAM, FCM_OP_BYPASS_ENTER,
        FCM_OP_BYPASS_PROG, FCM_OP_BYPASS_EXIT, FCM_OP_CHIP_ERASE,
        FCM_OP_READ
    } fcm_op_t;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [19:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
    } fcm_bus_t;
endpackage

// File: rtl/fcm_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
module fcm_sync #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pins and clean copy
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] clean_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, cl_q;
    logic [W-1:0] cl_d;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            cl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : cl_q[i];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            cl_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            cl_q <= cl_d;
        end
    end
    assign clean_o = cl_q;
endmodule

// File: rtl/fcm_master.sv
// Host-side command master that drives a parallel NOR flash
`include "fcm_cfg.svh"
// How it works
// - Writes have ce_n and we_n low, oe_n high; reads hold we_n high.
// - Reset command is sent on an FCM_OP_RESET request before leaving autoselect; a time limit only sets tl_q.
// - Program is AA, 55, A0, then program_addr with program_byte.
// - Bypass entry is AA, 55, 20; bypass program is A0 then data.
// - Bypass exit is 90 then 00.
// - Chip erase is AA, 55, 80, AA, 55, 10.
// - Unlock cycles carry AA then 55.
// - Erase set-up 80 third, chip erase 10 sixth.
// - Reset command is a single F0 write.
module fcm_master
    import fcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Software register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic [19:0] flash_addr,
    output logic [7:0] byte_data_bus_o,
    output logic byte_data_bus_oe,
    input wire logic [7:0] byte_data_bus_i,
    input wire logic op_done_n_pin
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_GAP, ST_RDWAIT, ST_BUSY
    } st_t;

    st_t st_q, st_d;
    fcm_bus_t bus_q, bus_d;
    fcm_op_t op_q, op_d;
    logic [2:0] idx_q, idx_d;
    logic [2:0] len_q, len_d;
    logic [3:0] cnt_q, cnt_d;
    logic [19:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic [31:0] rdata_q, rdata_d;
    logic busy_op_q, busy_op_d;
    logic done_q, done_d;
    logic tl_q, tl_d;
    logic [8:0] clean;
    logic [7:0] dq_s;
    logic rdy_s;
    logic [19:0] cyc_a;
    logic [7:0] cyc_d;
    logic cyc_rd;

    fcm_sync #(.W(9)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_i({op_done_n_pin, byte_data_bus_i}),
        .clean_o(clean)
    );
    assign dq_s = clean[7:0];
    assign rdy_s = clean[8];

    // Address and data of bus cycle idx for the current operation
    always_comb begin
        cyc_a = `FCM_UNLOCK_ADDR;
        cyc_d = `FCM_CMD_RESET;
        cyc_rd = 1'b0;
        unique case (op_q)
            FCM_OP_RESET: cyc_d = `FCM_CMD_RESET;
            FCM_OP_READ: begin
                cyc_rd = 1'b1;
                cyc_a = addr_q;
            end
            FCM_OP_BYPASS_PROG: begin
                cyc_d = (idx_q == 3'd0) ? `FCM_CMD_PROG : data_q;
                if (idx_q == 3'd1) cyc_a = addr_q;
            end
            FCM_OP_BYPASS_EXIT:
                cyc_d = (idx_q == 3'd0) ? `FCM_CMD_AUTOSEL : `FCM_CMD_BYP_EXIT;
            default: begin
                // Unlocked sequences: AA 55 at cycles 0,1, and for chip erase also at 3,4
                unique case (idx_q)
                    3'd0: cyc_d = `FCM_CMD_UNLOCK1;
                    3'd3: begin
                        // Program ends on its fourth cycle with address and data
                        if (op_q == FCM_OP_PROGRAM) begin
                            cyc_a = addr_q;
                            cyc_d = data_q;
                        end else begin
                            cyc_d = `FCM_CMD_UNLOCK1;
                        end
                    end
                    3'd1, 3'd4: cyc_d = `FCM_CMD_UNLOCK2;
                    3'd2: begin
                        unique case (op_q)
                            FCM_OP_AUTOSEL: cyc_d = `FCM_CMD_AUTOSEL;
                            FCM_OP_PROGRAM: cyc_d = `FCM_CMD_PROG;
                            FCM_OP_BYPASS_ENTER: cyc_d = `FCM_CMD_BYPASS;
                            default: cyc_d = `FCM_CMD_ERASE_SETUP;
                        endcase
                    end
                    3'd5: cyc_d = `FCM_CMD_CHIP_ERASE;
                    default: begin
                        cyc_a = addr_q;
                        cyc_d = data_q;
                    end
                endcase
            end
        endcase
    end

    always_comb begin
        st_d = st_q;
        bus_d = bus_q;
        op_d = op_q;
        idx_d = idx_q;
        len_d = len_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        data_d = data_q;
        rbyte_d = rbyte_q;
        busy_op_d = busy_op_q;
        done_d = done_q;
        tl_d = tl_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr && reg_addr == `FCM_REG_ADDR) addr_d = reg_wdata[19:0];
        if (reg_wr && reg_addr == `FCM_REG_DATA) data_d = reg_wdata[7:0];
        if (reg_wr && reg_addr == `FCM_REG_STAT && reg_wdata[1]) done_d = 1'b0;
        if (reg_wr && reg_addr == `FCM_REG_STAT && reg_wdata[2]) tl_d = 1'b0;
        if (reg_rd) begin
            unique case (reg_addr)
                `FCM_REG_ADDR: rdata_d = {12'h000, addr_q};
                `FCM_REG_DATA: rdata_d = {24'h000000, data_q};
                `FCM_REG_STAT:
                    rdata_d = {28'h0000000, !rdy_s, tl_q, done_q,
                               st_q != ST_IDLE};
                `FCM_REG_RDATA: rdata_d = {24'h000000, rbyte_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        unique case (st_q)
            ST_IDLE: begin
                if (reg_wr && reg_addr == `FCM_REG_CTRL && rdy_s) begin
                    op_d = fcm_op_t'(reg_wdata[3:0]);
                    idx_d = 3'd0;
                    unique case (fcm_op_t'(reg_wdata[3:0]))
                        FCM_OP_RESET, FCM_OP_READ: len_d = 3'd1;
                        FCM_OP_AUTOSEL, FCM_OP_BYPASS_ENTER: len_d = 3'd3;
                        FCM_OP_PROGRAM: len_d = 3'd4;
                        FCM_OP_CHIP_ERASE: len_d = 3'd6;
                        default: len_d = 3'd2;
                    endcase
                    busy_op_d = reg_wdata[3:0] == FCM_OP_PROGRAM ||
                        reg_wdata[3:0] == FCM_OP_BYPASS_PROG ||
                        reg_wdata[3:0] == FCM_OP_CHIP_ERASE;
                    st_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address and data settle with we_n high; oe_n goes low here for reads
                bus_d.addr = cyc_a;
                bus_d.dq_o = cyc_d;
                bus_d.dq_oe = !cyc_rd;
                bus_d.ce_n = 1'b0;
                bus_d.oe_n = !cyc_rd;
                cnt_d = 4'd0;
                st_d = cyc_rd ? ST_RDWAIT : ST_PULSE;
            end
            ST_PULSE: begin
                bus_d.we_n = 1'b0;
                cnt_d = cnt_q + 4'd1;
                if (cnt_q == 4'(`FCM_PULSE_CYC)) begin
                    bus_d.we_n = 1'b1; // data held past rise
                    cnt_d = 4'd0;
                    st_d = ST_GAP;
                end
            end
            ST_RDWAIT: begin
                cnt_d = cnt_q + 4'd1;
                if (cnt_q == 4'(`FCM_RD_CYC)) begin
                    rbyte_d = dq_s;
                    bus_d.oe_n = 1'b1;
                    cnt_d = 4'd0;
                    st_d = ST_GAP;
                end
            end
            ST_GAP: begin
                bus_d.ce_n = 1'b1;
                bus_d.dq_oe = 1'b0;
                cnt_d = cnt_q + 4'd1;
                if (cnt_q == 4'(`FCM_GAP_CYC)) begin
                    idx_d = idx_q + 3'd1;
                    if (idx_q + 3'd1 == len_q) begin
                        st_d = busy_op_q ? ST_BUSY : ST_IDLE;
                        if (!busy_op_q) done_d = 1'b1;
                    end else begin
                        st_d = ST_SETUP;
                    end
                end
            end
            ST_BUSY: begin
                cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'd1;
                if (cnt_q == 4'hf && rdy_s) begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
                if (dq_s[5] && !rdy_s) tl_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            bus_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                       addr: 20'h00000, dq_o: 8'h00, dq_oe: 1'b0};
            op_q <= FCM_OP_RESET;
            idx_q <= 3'd0;
            len_q <= 3'd1;
            cnt_q <= 4'd0;
            addr_q <= 20'h00000;
            data_q <= 8'hff;
            rbyte_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            busy_op_q <= 1'b0;
            done_q <= 1'b0;
            tl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bus_q <= bus_d;
            op_q <= op_d;
            idx_q <= idx_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            data_q <= data_d;
            rbyte_q <= rbyte_d;
            rdata_q <= rdata_d;
            busy_op_q <= busy_op_d;
            done_q <= done_d;
            tl_q <= tl_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign flash_ce_n = bus_q.ce_n;
    assign flash_we_n = bus_q.we_n;
    assign flash_oe_n = bus_q.oe_n;
    assign flash_addr = bus_q.addr;
    assign byte_data_bus_o = bus_q.dq_o;
    assign byte_data_bus_oe = bus_q.dq_oe;
endmodule

// File: sim/fcm_master_props.sv
// Pin-level assertions for the flash command master
module fcm_master_props (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Flash pins
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] byte_data_bus_o,
    input wire logic byte_data_bus_oe,
    input wire logic op_done_n_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_write_gated: assert property (!flash_we_n |->
        !flash_ce_n && flash_oe_n && byte_data_bus_oe)
        else $error("write strobe without enables");
    a_read_quiet: assert property (!flash_oe_n |->
        flash_we_n && !byte_data_bus_oe) else $error("bus driven in read");
    a_pulse_width: assert property ($fell(flash_we_n) |->
        !flash_we_n [*5] ##1 flash_we_n) else $error("strobe width");
    a_addr_setup: assert property ($fell(flash_we_n) |->
        !$past(flash_ce_n) && $past(byte_data_bus_oe))
        else $error("no setup before strobe");
    a_addr_hold: assert property (!flash_we_n && !$past(flash_we_n) |->
        $stable(flash_addr) && $stable(byte_data_bus_o))
        else $error("address moved in strobe");
    a_data_hold: assert property ($rose(flash_we_n) |->
        $stable(byte_data_bus_o)) else $error("data moved at strobe end");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
        flash_ce_n && flash_we_n && flash_oe_n && !byte_data_bus_oe)
        else $error("pins active after reset");
    a_busy_quiet: assert property (!op_done_n_pin [*8] |->
        flash_we_n) else $error("write while busy");
endmodule
bind fcm_master fcm_master_props u_props (.clk(clk), .sys_rst(sys_rst),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
    .byte_data_bus_o(byte_data_bus_o),
    .byte_data_bus_oe(byte_data_bus_oe), .op_done_n_pin(op_done_n_pin));

// File: sim/fcm_flash_model.sv
// Behavioural model of the parallel flash device
module fcm_flash_model #(
    parameter logic [7:0] MAKER = 8'h5a, // arbitrary
    parameter logic [7:0] PART = 8'hc3, // arbitrary
    parameter logic [15:0] PROT = 16'h0021,
    parameter int BUSY_NS = 400
) (
    // Control and address pins
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [19:0] addr,
    // Data and ready
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic rdy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [logic [19:0]];
    logic [19:0] a_lat;
    logic [7:0] d;
    int st = 0;
    int bz;
    time t0;
    logic pwr_ok = 1'b1; // Supply taken as above lockout_threshold
    wire wr = pwr_ok && !ce_n && !we_n && oe_n;
    initial begin
        rdy = 1'b1;
        dout = 8'h3c;
    end
    always @(posedge wr) begin
        a_lat = addr;
        t0 = $time;
    end
    always @(ce_n, oe_n, addr, st) begin
        if (!ce_n && !oe_n) begin
            if (st == 3) begin
                dout = addr[7:0] == 8'h00 ? MAKER : addr[7:0] == 8'h01 ? PART
                    : {7'h0, addr[7:0] == 8'h02 && PROT[addr[19:16]]};
            end else begin
                dout = mem.exists(addr) ? mem[addr] : 8'hff;
            end
        end else begin
            dout = ~dout;
        end
    end
    always @(negedge wr) begin
        d = din;
        bz = 0;
        if (rdy && $time - t0 >= 5) begin
            case (st)
                0: st = d == 8'haa ? 1 : 0;
                1: st = d == 8'h55 ? 2 : 0;
                2: st = d == 8'h90 ? 3 : d == 8'ha0 ? 4 : d == 8'h20 ? 5
                    : d == 8'h80 ? 8 : 0;
                3: st = d == 8'hf0 ? 0 : 3;
                5: st = d == 8'ha0 ? 6 : d == 8'h90 ? 7 : 0;
                8: st = d == 8'haa ? 9 : 0;
                9: st = d == 8'h55 ? 10 : 0;
                10: begin
                    if (d == 8'h10) begin
                        mem.delete();
                        bz = 4 * BUSY_NS;
                    end
                    st = 0;
                end
                4, 6: begin
                    mem[a_lat] = (mem.exists(a_lat) ? mem[a_lat] : 8'hff) & d;
                    st = st == 6 ? 5 : 0;
                    bz = BUSY_NS;
                end
                default: st = 0;
            endcase
            if (bz > 0) begin
                rdy = 1'b0;
                #(bz);
                rdy = 1'b1;
            end
        end
    end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the flash command master
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary
    localparam logic [7:0] PART = 8'hc3; // arbitrary
    localparam logic [15:0] PROT = 16'h0021;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic ce_n, we_n, oe_n, oe, rdy;
    logic [19:0] fa, a;
    logic [7:0] qo, fd, dq, d;
    logic [7:0] sh [logic [19:0]];
    logic [19:0] al [$];
    int mismatches = 0, checks = 0, cyc = 0, seed = 32'h38ca1c86;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            stop_test();
        end
    end
    assign dq = oe ? qo : fd;
    fcm_master dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_ce_n(ce_n), .flash_we_n(we_n),
        .flash_oe_n(oe_n), .flash_addr(fa), .byte_data_bus_o(qo),
        .byte_data_bus_oe(oe), .byte_data_bus_i(dq), .op_done_n_pin(rdy));
    fcm_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(PROT)) u_flash (
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa), .din(dq),
        .dout(fd), .rdy(rdy));
    function automatic logic [7:0] exv(input logic [19:0] x);
        return sh.exists(x) ? sh[x] : 8'hff;
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t %s %h %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ra, input logic [31:0] rd_);
        @(posedge clk);
        reg_addr <= ra;
        reg_wdata <= rd_;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ra);
        @(posedge clk);
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic op(input logic [3:0] c, input logic [19:0] x,
        input logic [7:0] y);
        int n;
        n = 0;
        wr(4'h1, {12'h0, x});
        wr(4'h2, {24'h0, y});
        wr(4'h0, {28'h0, c});
        do begin
            rd(4'h3);
            n++;
        end while (v[1] !== 1'b1 && n < 400);
        chk(v[1], 1'b1, "op done");
        chk(v[0], 1'b0, "idle after op");
        wr(4'h3, 32'h2);
    endtask
    task automatic rdf(input logic [19:0] x, input logic [7:0] e);
        op(4'h7, x, 8'h00);
        rd(4'h4);
        chk(v, {24'h0, e}, "flash read");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) rd(4'h3);
        chk(v[3], 1'b0, "device ready");
        rd(4'hf);
        chk(v, 32'h0, "unmapped read");
        op(4'h1, 20'h0, 8'h0);
        rdf(20'h00000, MAKER);
        rdf(20'h00001, PART);
        for (int i = 0; i < 16; i += 5) begin
            rdf({i[3:0], 16'h0002}, {7'h0, PROT[i]});
        end
        op(4'h0, 20'h0, 8'h0);
        rdf(20'h00000, exv(20'h0));
        $display("test identification done");
        for (int k = 0; k < 2; k++) begin
            if (k == 1) op(4'h3, 20'h0, 8'h0);
            repeat (4) begin
                a = al.size() == 2 ? al[0] : 20'($random(seed));
                d = 8'($random(seed));
                al.push_back(a);
                sh[a] = exv(a) & d;
                op(k == 1 ? 4'h4 : 4'h2, a, d);
            end
            if (k == 1) op(4'h5, 20'h0, 8'h0);
            foreach (al[i]) rdf(al[i], exv(al[i]));
            $display("test program pass %0d done", k);
        end
        op(4'h6, 20'h0, 8'h0);
        sh.delete();
        foreach (al[i]) rdf(al[i], exv(al[i]));
        $display("test chip erase done");
        stop_test();
    end
endmodule
